// ===== hw/cfg_ids_pkg.sv
// Package: offsets, field positions and constant values of the status and class-code block
package cfg_ids_pkg;
   // ------------------------------------------------------------
   // Configuration offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] BUS_EVENT_STATUS_OFS     = 8'h06; // 16-bit status
   localparam logic [7:0] DESIGN_REVISION_CODE_OFS = 8'h08; // 8-bit revision
   localparam logic [7:0] FUNCTION_CLASS_CODE_OFS  = 8'h09; // 24-bit class code
   localparam logic [7:0] CAPABILITY_POINTER_OFS   = 8'h34; // Where the list pointer lives
   localparam int         DWORD_LSB                = 2;     // Dword index starts here

   // ------------------------------------------------------------
   // Status field positions
   // ------------------------------------------------------------
   localparam int TIMING_LSB      = 9;  // Target-select timing, bits 10:9
   localparam int PARITY_FLAG_POS = 8;  // Master parity error flag
   localparam int B2B_POS         = 7;  // Back-to-back capable
   localparam int FAST_CLK_POS    = 5;  // Fast clock capable
   localparam int CAP_LIST_POS    = 4;  // Capabilities list flag
   localparam int STATUS_HALF_LSB = 16; // Status is the upper half of its dword

   // ------------------------------------------------------------
   // Target-select timing codes
   // ------------------------------------------------------------
   localparam logic [1:0] TIMING_FAST     = 2'h0;
   localparam logic [1:0] TIMING_MEDIUM   = 2'h1;
   localparam logic [1:0] TIMING_SLOW     = 2'h2;
   localparam logic [1:0] TIMING_RESERVED = 2'h3;

   // ------------------------------------------------------------
   // Fixed capability values of this function
   // ------------------------------------------------------------
   localparam logic [1:0] TIMING_VALUE   = TIMING_MEDIUM; // Slowest decode we use
   localparam logic       B2B_VALUE      = 1'b0;          // No fast back-to-back
   localparam logic       FAST_CLK_VALUE = 1'b0;          // 33 MHz only
   localparam logic       CAP_LIST_VALUE = 1'b1;          // Pointer list present
   localparam logic       FLAG_RESET     = 1'b0;          // Parity flag after reset

   // ------------------------------------------------------------
   // Class code bytes
   // ------------------------------------------------------------
   localparam logic [7:0] BASE_CLASS_VALUE = 8'h0C; // Serial bus controller
   localparam logic [7:0] SUB_CLASS_VALUE  = 8'h03; // USB host controller
   localparam logic [7:0] PROG_IF_FULL     = 8'h10; // Full-speed open host
   localparam logic [7:0] PROG_IF_HIGH     = 8'h20; // Enhanced high-speed host
   localparam logic [7:0] REVISION_DEFAULT = 8'hA5; // Arbitrary neutral value

   localparam logic [31:0] RDATA_RESET = 32'h0000_0000;
endpackage

// ===== hw/cfg_status_ids.sv
// Read-only status, revision and class-code slice of a host function's configuration header
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Timing field reports slowest decode; 11 reserved
// - Timing codes 00 fast, 01 medium
// - Parity flag needs PERR, mastership, parity enable
// - Back-to-back bit one only if supported
// - Clock bit: zero 33 MHz, one 66
// - Capability flag marks list pointer at 34h
// - Whole status register read-only to software
// - Eight-bit fixed revision code at 08h
// - 24-bit class code at 09h, three bytes
// - Base class byte reads 0Ch
// - Sub-class byte reads 03h
// - Programming interface 10h full, 20h high
module cfg_status_ids #(
   parameter logic       HIGH_SPEED_FUNC = 1'b0,                          // 1 = enhanced function
   parameter logic [7:0] REVISION_CODE   = cfg_ids_pkg::REVISION_DEFAULT  // Arbitrary value
) (
   input  wire logic        clock_i,                    // 200 MHz clock
   input  wire logic        rst_i,                      // Sync reset, active high
   input  wire logic        cfg_rd_i,                   // Configuration read strobe
   input  wire logic        cfg_wr_i,                   // Configuration write strobe
   input  wire logic [7:0]  cfg_addr_i,                 // Byte address, dword used
   input  wire logic [31:0] cfg_wdata_i,                // Write data, ignored here
   input  wire logic        parity_response_enable_i,   // Command register bit 6
   input  wire logic        bus_master_active_i,        // We own the current transfer
   input  wire logic        perr_driven_read_i,         // We drove PERR# on a read
   input  wire logic        perr_seen_write_i,          // PERR# seen on our write
   input  wire logic        parity_flag_clear_i,        // Clear pulse for the parity flag
   output logic [31:0]      cfg_rdata_o,                // Read data
   output logic             cfg_ack_o,                  // Access done, one cycle
   output logic             master_parity_error_flag_o  // Current parity flag
);
   import cfg_ids_pkg::*;

   // ------------------------------------------------------------
   // Declarations
   // ------------------------------------------------------------
   logic        parity_flag_reg;   // Sticky master parity error
   logic        parity_flag_set;   // Qualified parity event
   logic [15:0] status_word;       // Assembled status
   logic [23:0] class_word;        // Assembled class code
   logic [7:0]  prog_if;           // Per-function interface byte
   logic [5:0]  dword_idx;         // Decoded dword
   logic [31:0] rdata_next;        // Read mux output
   logic        unused_wdata;      // Write data is deliberately dropped

   assign unused_wdata = ^cfg_wdata_i;
   assign dword_idx    = cfg_addr_i[7:DWORD_LSB];

   // ------------------------------------------------------------
   // Master parity error flag
   // ------------------------------------------------------------
   // All three conditions must hold at once
   assign parity_flag_set = (perr_driven_read_i | perr_seen_write_i)
                            & bus_master_active_i & parity_response_enable_i;

   // Set wins over clear so an event in the clear cycle survives
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         parity_flag_reg <= FLAG_RESET;
      end else if (parity_flag_set) begin
         parity_flag_reg <= 1'b1;
      end else if (parity_flag_clear_i) begin
         parity_flag_reg <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Constant fields
   // ------------------------------------------------------------
   // Software writes never reach any of these; strobes only ack
   always_comb begin
      status_word                          = 16'h0000;
      status_word[TIMING_LSB+1:TIMING_LSB] = TIMING_VALUE;
      status_word[PARITY_FLAG_POS]         = parity_flag_reg;
      status_word[B2B_POS]                 = B2B_VALUE;
      status_word[FAST_CLK_POS]            = FAST_CLK_VALUE;
      status_word[CAP_LIST_POS]            = CAP_LIST_VALUE;
   end

   assign prog_if    = HIGH_SPEED_FUNC ? PROG_IF_HIGH : PROG_IF_FULL;
   assign class_word = {BASE_CLASS_VALUE, SUB_CLASS_VALUE, prog_if};

   // ------------------------------------------------------------
   // Read mux
   // ------------------------------------------------------------
   // Unmapped dwords and the command half read zero; owned elsewhere
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (dword_idx == BUS_EVENT_STATUS_OFS[7:DWORD_LSB]) begin
         rdata_next = {status_word, 16'h0000};
      end else if (dword_idx == DESIGN_REVISION_CODE_OFS[7:DWORD_LSB]) begin
         rdata_next = {class_word, REVISION_CODE};
      end
   end

   // ------------------------------------------------------------
   // Bus answer
   // ------------------------------------------------------------
   // Reads load data; writes only acknowledge and change nothing
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         cfg_rdata_o <= RDATA_RESET;
         cfg_ack_o   <= 1'b0;
      end else begin
         cfg_ack_o <= cfg_rd_i | cfg_wr_i;
         if (cfg_rd_i) begin
            cfg_rdata_o <= rdata_next;
         end
      end
   end

   // Flag mirror, registered so the output is a flop
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         master_parity_error_flag_o <= FLAG_RESET;
      end else begin
         // Or-ing in the event lets the pin rise with the status bit; on a clear it falls one cycle later
         master_parity_error_flag_o <= parity_flag_reg | parity_flag_set;
      end
   end

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   property p_timing;
      @(posedge clock_i) disable iff (rst_i)
      cfg_rd_i && dword_idx == 6'h01 |=> cfg_rdata_o[26:25] == 2'h1;
   endproperty
   a_timing: assert property (p_timing) else $error("timing field wrong");

   property p_timing_legal;
      @(posedge clock_i) disable iff (rst_i)
      cfg_rd_i && dword_idx == 6'h01 |=> cfg_rdata_o[26:25] != 2'h3;
   endproperty
   a_timing_legal: assert property (p_timing_legal) else $error("reserved timing");

   property p_flag_set;
      @(posedge clock_i) disable iff (rst_i)
      (perr_driven_read_i || perr_seen_write_i) && bus_master_active_i
      && parity_response_enable_i |=> parity_flag_reg ##1 master_parity_error_flag_o;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("parity flag not set");

   property p_flag_hold;
      @(posedge clock_i) disable iff (rst_i)
      !parity_flag_reg && !(bus_master_active_i && parity_response_enable_i)
      |=> !parity_flag_reg;
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("parity flag set wrongly");

   property p_caps;
      @(posedge clock_i) disable iff (rst_i)
      cfg_rd_i && dword_idx == 6'h01 |=>
      !cfg_rdata_o[23] && !cfg_rdata_o[21] && cfg_rdata_o[20];
   endproperty
   a_caps: assert property (p_caps) else $error("capability bits wrong");

   property p_reserved;
      @(posedge clock_i) disable iff (rst_i)
      cfg_rd_i && dword_idx == 6'h01 |=>
      cfg_rdata_o[22] == 1'b0 && cfg_rdata_o[19:16] == 4'h0 && cfg_rdata_o[15:0] == 16'h0000;
   endproperty
   a_reserved: assert property (p_reserved) else $error("reserved bits set");

   property p_class;
      @(posedge clock_i) disable iff (rst_i)
      cfg_rd_i && dword_idx == 6'h02 |=>
      cfg_rdata_o == {8'h0C, 8'h03, (HIGH_SPEED_FUNC ? 8'h20 : 8'h10), REVISION_CODE};
   endproperty
   a_class: assert property (p_class) else $error("class or revision wrong");

   property p_write_quiet;
      @(posedge clock_i) disable iff (rst_i)
      cfg_wr_i && !cfg_rd_i |=> cfg_ack_o && $stable(cfg_rdata_o);
   endproperty
   a_write_quiet: assert property (p_write_quiet) else $error("write changed data");

   property p_write_no_flag;
      @(posedge clock_i) disable iff (rst_i)
      cfg_wr_i && !parity_flag_set && !parity_flag_clear_i
      |=> parity_flag_reg == $past(parity_flag_reg);
   endproperty
   a_write_no_flag: assert property (p_write_no_flag) else $error("write moved flag");

   // Every strobe is answered exactly one cycle later
   property p_ack_follows;
      @(posedge clock_i) disable iff (rst_i)
      cfg_rd_i || cfg_wr_i |=> cfg_ack_o;
   endproperty
   a_ack_follows: assert property (p_ack_follows) else $error("ack missing");

   // Without a strobe there is no answer, so ack stands one cycle only
   property p_ack_single;
      @(posedge clock_i) disable iff (rst_i)
      !cfg_rd_i && !cfg_wr_i |=> !cfg_ack_o;
   endproperty
   a_ack_single: assert property (p_ack_single) else $error("ack without strobe");

   // A clear with no event in the same cycle drops the flag
   property p_flag_clear;
      @(posedge clock_i) disable iff (rst_i)
      !parity_flag_set && parity_flag_clear_i |=> !parity_flag_reg;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("parity flag not cleared");

   // Reset returns the answer and the flag to rest in one edge
   property p_reset_values;
      @(posedge clock_i)
      rst_i |=> !cfg_ack_o && cfg_rdata_o == RDATA_RESET
      && master_parity_error_flag_o == FLAG_RESET;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("reset values wrong");

   c_status_read: cover property (@(posedge clock_i) cfg_rd_i && dword_idx == 6'h01);
   c_class_read:  cover property (@(posedge clock_i) cfg_rd_i && dword_idx == 6'h02);
   c_flag_set:    cover property (@(posedge clock_i) parity_flag_set ##1 parity_flag_reg);
   c_set_clear:   cover property (@(posedge clock_i) parity_flag_set && parity_flag_clear_i);
   c_write:       cover property (@(posedge clock_i) cfg_wr_i ##1 cfg_ack_o);
endmodule
`default_nettype wire

// ===== tb/cfg_host_model.sv
// Behavioural host bridge that issues configuration cycles
`timescale 1ns/1ps
`default_nettype none
module cfg_host_model (
   input  wire logic        clock_i, // Bus clock
   input  wire logic        ack_i,   // Access done
   input  wire logic [31:0] rdata_i, // Read data
   output var logic         rd_o,    // Read strobe
   output var logic         wr_o,    // Write strobe
   output var logic [7:0]   addr_o,  // Byte address
   output var logic [31:0]  wdata_o  // Write data
);
   // ------------------------------------------------------------
   // Idle bus and one-cycle access
   // ------------------------------------------------------------
   initial begin
      rd_o = 1'b0;
      wr_o = 1'b0;
      addr_o = 8'h00;
      wdata_o = 32'h0000_0000;
   end

   // Released lines flip so a stale value can never pass as fresh
   task automatic access(input logic wr, input logic [7:0] a, input logic [31:0] d,
                         output logic [31:0] q, output logic ok);
      ok = 1'b0;
      @(negedge clock_i);
      rd_o = ~wr;
      wr_o = wr;
      addr_o = a;
      wdata_o = d;
      @(negedge clock_i);
      rd_o = 1'b0;
      wr_o = 1'b0;
      addr_o = ~a;
      wdata_o = ~d;
      // Bounded wait for the answer
      for (int i = 0; i < 4 && !ok; i++) begin
         if (ack_i === 1'b1) begin
            ok = 1'b1;
            q = rdata_i;
         end
         else @(negedge clock_i);
      end
   endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the status, revision and class-code slice
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import cfg_ids_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        clock_i = 1'b0; // 200 MHz clock
   logic        rst_i = 1'b1;   // Sync reset
   logic        par_en = 1'b0;  // Parity response enable
   logic        master = 1'b0;  // Bus mastership
   logic        perr_rd = 1'b0; // PERR driven on read
   logic        perr_wr = 1'b0; // PERR seen on write
   logic        clr = 1'b0;     // Flag clear pulse
   logic        rd, wr, ack_fs, ack_hs, flag_fs, flag_hs;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata_fs, rdata_hs, q, r;
   logic        ok;
   logic        flag_exp = 1'b0; // Predicted parity flag
   int          seed = 7881;
   int          error_cnt = 0;
   int          samples_checked = 0;

   always #2.5 clock_i = ~clock_i;

   // Host bridge drives both functions; the full-speed one answers it
   cfg_host_model u_cfg_host_model (.clock_i(clock_i), .ack_i(ack_fs), .rdata_i(rdata_fs),
      .rd_o(rd), .wr_o(wr), .addr_o(addr), .wdata_o(wdata));
   cfg_status_ids #(.HIGH_SPEED_FUNC(1'b0)) u_cfg_status_ids (.clock_i(clock_i),
      .rst_i(rst_i), .cfg_rd_i(rd), .cfg_wr_i(wr), .cfg_addr_i(addr), .cfg_wdata_i(wdata),
      .parity_response_enable_i(par_en), .bus_master_active_i(master),
      .perr_driven_read_i(perr_rd), .perr_seen_write_i(perr_wr), .parity_flag_clear_i(clr),
      .cfg_rdata_o(rdata_fs), .cfg_ack_o(ack_fs), .master_parity_error_flag_o(flag_fs));
   cfg_status_ids #(.HIGH_SPEED_FUNC(1'b1)) u_cfg_status_ids_hs (.clock_i(clock_i),
      .rst_i(rst_i), .cfg_rd_i(rd), .cfg_wr_i(wr), .cfg_addr_i(addr), .cfg_wdata_i(wdata),
      .parity_response_enable_i(par_en), .bus_master_active_i(master),
      .perr_driven_read_i(perr_rd), .perr_seen_write_i(perr_wr), .parity_flag_clear_i(clr),
      .cfg_rdata_o(rdata_hs), .cfg_ack_o(ack_hs), .master_parity_error_flag_o(flag_hs));

   // ------------------------------------------------------------
   // Checking helpers
   // ------------------------------------------------------------
   task automatic test_done;
      $display("comparisons %0d, mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Expected dword: status in the upper half of 04h, ids at 08h
   function automatic logic [31:0] exp_rd(input logic hs, input logic [7:0] a, input logic f);
      case (a[7:2])
         6'h01: exp_rd = {5'h00, 2'h1, f, 4'h1, 4'h0, 16'h0000};
         6'h02: exp_rd = {8'h0C, 8'h03, hs ? 8'h20 : 8'h10, REVISION_DEFAULT};
         default: exp_rd = 32'h0000_0000;
      endcase
   endfunction

   // One access; a missing answer ends the run
   task automatic go(input logic w, input logic [7:0] a, input logic [31:0] d);
      u_cfg_host_model.access(w, a, d, q, ok);
      if (!ok) begin
         error_cnt++;
         test_done();
      end
      chk({31'h0, ack_hs}, 32'h0000_0001);
      // Both answers must drop again after one cycle
      @(negedge clock_i);
      chk({30'h0, ack_fs, ack_hs}, 32'h0000_0000);
   endtask

   // Optional write of ones, then read back on both functions
   task automatic wr_rd(input logic w, input logic [7:0] a);
      if (w) go(1'b1, a, 32'hFFFF_FFFF);
      go(1'b0, a, 32'h0000_0000);
      chk(q, exp_rd(1'b0, a, flag_exp));
      chk(rdata_hs, exp_rd(1'b1, a, flag_exp));
   endtask

   // ------------------------------------------------------------
   // Main sequence: corners after reset, then random parity and accesses
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clock_i);
      @(negedge clock_i) rst_i = 1'b0;
      foreach (r[i]) if (i < 6) wr_rd(i[0], 8'h06 + i[7:0]);
      wr_rd(1'b1, 8'hFC);
      for (int n = 0; n < 300; n++) begin
         r = $random(seed);
         @(negedge clock_i);
         {par_en, master, perr_rd, perr_wr} = r[3:0];
         clr = r[4] & r[5];
         flag_exp = ((r[1] | r[0]) & r[2] & r[3]) | (flag_exp & ~clr);
         @(negedge clock_i);
         {par_en, master, perr_rd, perr_wr, clr} = 5'h00;
         repeat (3) @(negedge clock_i);
         chk({31'h0, flag_fs}, {31'h0, flag_exp});
         chk({31'h0, flag_hs}, {31'h0, flag_exp});
         wr_rd(r[6], r[7] ? r[15:8] : {4'h0, r[9], ~r[9], r[11:10]});
      end
      // Corner: flag set by a read error, seen in status, then a mid-run reset
      @(negedge clock_i) {par_en, master, perr_rd} = 3'h7;
      @(negedge clock_i) {par_en, master, perr_rd} = 3'h0;
      go(1'b0, 8'h06, 32'h0000_0000);
      chk(q, exp_rd(1'b0, 8'h06, 1'b1));
      rst_i = 1'b1;
      repeat (2) @(negedge clock_i);
      chk({28'h0, flag_fs, flag_hs, ack_fs, ack_hs}, 32'h0000_0000);
      chk(rdata_fs | rdata_hs, RDATA_RESET);
      rst_i = 1'b0;
      flag_exp = 1'b0;
      wr_rd(1'b0, 8'h06);
      test_done();
   end
endmodule
`default_nettype wire
